// >>> rtl/tsw_regs.vh
// Purpose: Constants shared by the time-slot switch files
// Assumes: Included by bare name
// Notes:   Field positions of the control byte and connection entries
`ifndef TSW_REGS_VH
`define TSW_REGS_VH

// Control byte fields
`define TSW_CTRL_SPLIT      7
`define TSW_CTRL_MSG_ALL    6
`define TSW_CTRL_MSEL_HI    4
`define TSW_CTRL_MSEL_LO    3
`define TSW_CTRL_STRM_HI    2
`define TSW_CTRL_RST        8'h00

// Memory select codes
`define TSW_MSEL_DATA       2'h0
`define TSW_MSEL_CML        2'h2
`define TSW_MSEL_CMH        2'h3

// Connection high entry fields
`define TSW_CMH_OE          0
`define TSW_CMH_CTRL        1
`define TSW_CMH_MSG         2
`define TSW_CMH_RST         3'h0

// Reset value of connection low entries and data store
`define TSW_MEM_RST         8'h00

// Connection low entry fields, switched mode
`define TSW_CML_STRM_HI     7
`define TSW_CML_STRM_LO     5

// Address line selecting the channel locations
`define TSW_ADDR_MEM        5

// Sizes
`define TSW_STREAMS         8
`define TSW_CHANNELS        32
`define TSW_FIFO_DEPTH      8
`define TSW_RATE_KBPS       2048

`endif

// >>> rtl/tsw_fifo.v
// Purpose: Flop-based FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes:   Depth must be a power of two
`timescale 1ns/1ps
module tsw_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 8,
	parameter AW    = 3
) (
	// Clock and reset
	input  wire             i_sys_clk,
	input  wire             i_srst,
	// Fill side
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	// Drain side
	output wire             o_out_valid,
	input  wire             i_out_ready,
	output wire [WIDTH-1:0] o_out_data
);
	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW:0]      wr_q;
	reg [AW:0]      rd_q;
	wire            full;
	wire            empty;
	wire            push;
	wire            pop;

	assign full        = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
	assign empty       = (wr_q == rd_q);
	assign o_in_ready  = ~full;
	assign o_out_valid = ~empty;
	assign o_out_data  = mem_q[rd_q[AW-1:0]];
	assign push        = i_in_valid & ~full;
	assign pop         = i_out_ready & ~empty;

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			wr_q <= {(AW+1){1'b0}};
			rd_q <= {(AW+1){1'b0}};
		end else begin
			if (push) begin
				mem_q[wr_q[AW-1:0]] <= i_in_data;
				wr_q                <= wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= rd_q + 1'b1;
			end
		end
	end
endmodule

// >>> rtl/tsw_switch.v
// Purpose: 256-channel time-slot switch with serial streams and processor port
// Assumes: All input pins but i_sys_clk and i_srst are asynchronous to i_sys_clk and pass a 3-flop synchroniser
// Notes:   Serial clock must be slow enough for i_sys_clk to see each level twice
//
// What this block does
// - Eight serial streams in and out, 32 channels
// - Any output channel carries any input channel
// - Frame low seen at a falling edge resets counters the next falling edge
// - Bit boundary every second serial clock fall
// - Acknowledge pulled low when access done
// - Data pins driven only for read data
// - Six address lines select locations
// - Drive enable low tri-states all serial stream outputs
// - Per-channel tri-state from connection high entry
// - Control output emits 256 control bits per frame
// - Frame of 32 eight-bit channels, continuous
// - Received bytes stored in 256x8 data store
// - Top address low selects control byte
// - Message bit sends connection low byte
`timescale 1ns/1ps
`include "tsw_regs.vh"
module tsw_switch (
	// Clock and reset
	input  wire        i_sys_clk,
	input  wire        i_srst,
	// Serial timing
	input  wire        i_serial_clk_4x,
	input  wire        i_frame_sync_n,
	// Serial streams
	input  wire [7:0]  i_serial_in_lines,
	output wire [7:0]  o_serial_out_lines,
	output wire [7:0]  o_serial_out_lines_oe,
	input  wire        i_out_drive_en,
	output wire        o_ctrl_serial_out,
	// Processor port
	input  wire        i_cs_n,
	input  wire        i_data_strobe,
	input  wire        i_rd_wr_n,
	input  wire [5:0]  i_port_addr,
	input  wire [7:0]  i_port_data,
	output wire [7:0]  o_port_data,
	output wire        o_port_data_oe,
	output wire        o_xfer_ack_n,
	output wire        o_xfer_ack_n_oe
);
	localparam NS = `TSW_STREAMS;
	localparam SW = 28;
	localparam ST_IDLE = 1'b0;
	localparam ST_ACK  = 1'b1;

	// Pin synchronisers: a level counts once stages two and three agree
	reg  [SW-1:0] s1_q;
	reg  [SW-1:0] s2_q;
	reg  [SW-1:0] s3_q;
	reg  [SW-1:0] lvl_q;
	wire [SW-1:0] raw;
	wire [SW-1:0] agree;
	wire [SW-1:0] lvl_d;

	assign raw   = {i_serial_clk_4x, i_frame_sync_n, i_serial_in_lines, i_out_drive_en,
			i_cs_n, i_data_strobe, i_rd_wr_n, i_port_addr, i_port_data};
	assign agree = ~(s2_q ^ s3_q);
	assign lvl_d = (s3_q & agree) | (lvl_q & ~agree);

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			s1_q  <= {SW{1'b1}};
			s2_q  <= {SW{1'b1}};
			s3_q  <= {SW{1'b1}};
			lvl_q <= {SW{1'b1}};
		end else begin
			s1_q  <= raw;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	wire       clk4    = lvl_q[27];
	wire       frame_n = lvl_q[26];
	wire [7:0] sin     = lvl_q[25:18];
	wire       out_drive_en     = lvl_q[17];
	wire       cs_n    = lvl_q[16];
	wire       strobe  = lvl_q[15];
	wire       rd      = lvl_q[14];
	wire [5:0] addr    = lvl_q[13:8];
	wire [7:0] wdata   = lvl_q[7:0];

	// Serial timing
	reg        fr_pend_q;
	reg        ph_q;
	reg  [7:0] bit_q;
	wire       fall     = clk4 & ~lvl_d[27];
	wire       boundary = fall & (fr_pend_q | ph_q);
	wire       mid      = fall & ~boundary;
	wire [7:0] bit_n    = fr_pend_q ? 8'h00 : bit_q + 8'h01;
	wire [4:0] chan_n   = bit_n[7:3];

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			fr_pend_q <= 1'b0;
			ph_q      <= 1'b0;
			bit_q     <= 8'hff;
		end else if (fall) begin
			fr_pend_q <= ~frame_n;
			ph_q      <= boundary ? 1'b0 : 1'b1;
			if (boundary) begin
				bit_q <= bit_n;
			end
		end
	end

	// Storage
	reg [7:0] ctrl_q;
	reg [7:0] dm_q  [0:255];
	reg [7:0] cml_q [0:255];
	reg [2:0] cmh_q [0:255];

	// Receive: per-stream shift, one FIFO entry per channel holds all eight bytes
	reg  [7:0]   rx_q [0:NS-1];
	wire [63:0]  rx_bytes;
	wire [68:0]  fifo_out;
	wire         fifo_in_ready;
	wire         fifo_out_valid;
	wire         rx_push = mid & (bit_q[2:0] == 3'h7);
	wire         port_go;

	genvar g;
	generate
		for (g = 0; g < NS; g = g + 1) begin : g_rx
			always @(posedge i_sys_clk) begin
				if (i_srst) begin
					rx_q[g] <= 8'h00;
				end else if (mid) begin
					rx_q[g] <= {rx_q[g][6:0], sin[g]};
				end
			end
			assign rx_bytes[8*g+7:8*g] = {rx_q[g][6:0], sin[g]};
		end
	endgenerate

	tsw_fifo #(
		.WIDTH (69),
		.DEPTH (`TSW_FIFO_DEPTH),
		.AW    (3)
	) u_fifo (
		.i_sys_clk   (i_sys_clk),
		.i_srst      (i_srst),
		.i_in_valid  (rx_push),
		.o_in_ready  (fifo_in_ready),
		.i_in_data   ({bit_q[7:3], rx_bytes}),
		.o_out_valid (fifo_out_valid),
		.i_out_ready (~port_go),
		.o_out_data  (fifo_out)
	);

	wire fifo_pop = fifo_out_valid & ~port_go;

	// Transmit
	reg  [7:0] tx_q    [0:NS-1];
	reg  [7:0] tx_oe_q;
	reg        cso_q;
	wire       load = boundary & (bit_n[2:0] == 3'h0);

	generate
		for (g = 0; g < NS; g = g + 1) begin : g_tx
			localparam [2:0] SN = g;
			wire [7:0] loc = {SN, chan_n};
			wire [7:0] cl  = cml_q[loc];
			wire       msg = cmh_q[loc][`TSW_CMH_MSG] | ctrl_q[`TSW_CTRL_MSG_ALL];
			wire [7:0] src = msg ? cl : dm_q[cl];
			always @(posedge i_sys_clk) begin
				if (i_srst) begin
					tx_q[g]    <= 8'hff;
					tx_oe_q[g] <= 1'b0;
				end else if (load) begin
					tx_q[g]    <= src;
					tx_oe_q[g] <= cmh_q[loc][`TSW_CMH_OE] | ctrl_q[`TSW_CTRL_MSG_ALL];
				end else if (boundary) begin
					tx_q[g] <= {tx_q[g][6:0], 1'b1};
				end
			end
			assign o_serial_out_lines[g]    = tx_q[g][7];
			assign o_serial_out_lines_oe[g] = tx_oe_q[g] & out_drive_en;
		end
	endgenerate

	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			cso_q <= 1'b1;
		end else if (boundary) begin
			cso_q <= cmh_q[bit_n][`TSW_CMH_CTRL];
		end
	end
	assign o_ctrl_serial_out = cso_q;

	// Processor port
	reg        st_q;
	reg  [7:0] rdata_q;
	wire       sel   = ~cs_n & strobe;
	wire [1:0] msel  = ctrl_q[`TSW_CTRL_MSEL_HI:`TSW_CTRL_MSEL_LO];
	wire [7:0] ploc  = {ctrl_q[`TSW_CTRL_STRM_HI:0], addr[4:0]};
	wire       split = ctrl_q[`TSW_CTRL_SPLIT];
	wire [1:0] rsel  = split ? `TSW_MSEL_DATA : msel;
	wire [1:0] wsel  = split ? `TSW_MSEL_CML : msel;
	reg  [7:0] rd_mux;

	assign port_go = (st_q == ST_IDLE) & sel;

	always @* begin
		if (!addr[`TSW_ADDR_MEM]) begin
			rd_mux = ctrl_q;
		end else begin
			case (rsel)
				`TSW_MSEL_CML: rd_mux = cml_q[ploc];
				`TSW_MSEL_CMH: rd_mux = {5'h00, cmh_q[ploc]};
				default:       rd_mux = dm_q[ploc];
			endcase
		end
	end

	integer i;
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			st_q    <= ST_IDLE;
			rdata_q <= 8'h00;
			ctrl_q  <= `TSW_CTRL_RST;
			for (i = 0; i < 256; i = i + 1) begin
				cmh_q[i] <= `TSW_CMH_RST;
				cml_q[i] <= `TSW_MEM_RST;
				dm_q[i]  <= `TSW_MEM_RST;
			end
		end else begin
			if (fifo_pop) begin
				for (i = 0; i < NS; i = i + 1) begin
					dm_q[{i[2:0], fifo_out[68:64]}] <= fifo_out[8*i+:8];
				end
			end
			case (st_q)
				ST_IDLE: begin
					if (sel) begin
						st_q <= ST_ACK;
						if (rd) begin
							rdata_q <= rd_mux;
						end else if (!addr[`TSW_ADDR_MEM]) begin
							ctrl_q <= wdata;
						end else if (wsel == `TSW_MSEL_CML) begin
							cml_q[ploc] <= wdata;
						end else if (wsel == `TSW_MSEL_CMH) begin
							cmh_q[ploc] <= wdata[2:0];
						end
					end
				end
				ST_ACK: begin
					if (!sel) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	reg ack_q;
	reg drv_q;
	always @(posedge i_sys_clk) begin
		if (i_srst) begin
			ack_q <= 1'b0;
			drv_q <= 1'b0;
		end else begin
			ack_q <= (st_q == ST_ACK) & sel;
			drv_q <= (st_q == ST_ACK) & sel & rd;
		end
	end

	assign o_port_data     = rdata_q;
	assign o_port_data_oe  = drv_q;
	assign o_xfer_ack_n    = 1'b0;
	assign o_xfer_ack_n_oe = ack_q;

	wire unused_ok = fifo_in_ready;
endmodule

// >>> verification/tsw_switch_assertions.sv
// Purpose: Port checks for tsw_switch
// Assumes: Bound to the design top
// Notes:   Sees ports only
`timescale 1ns/1ps
module tsw_switch_assertions (
	// Watched ports
	input wire       i_sys_clk,
	input wire       i_srst,
	input wire       i_out_drive_en,
	input wire       i_cs_n,
	input wire       i_data_strobe,
	input wire       i_rd_wr_n,
	input wire [7:0] o_serial_out_lines,
	input wire [7:0] o_serial_out_lines_oe,
	input wire       o_ctrl_serial_out,
	input wire       o_port_data_oe,
	input wire       o_xfer_ack_n,
	input wire       o_xfer_ack_n_oe
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_srst);
	a_ack_level: assert property (o_xfer_ack_n_oe
		|-> !o_xfer_ack_n && $past(!i_cs_n && i_data_strobe, 5)) else $error("ack level");
	a_ack_given: assert property ((!i_cs_n && i_data_strobe)[*7] |-> o_xfer_ack_n_oe)
		else $error("ack late");
	a_ack_release: assert property ((i_cs_n || !i_data_strobe)[*8]
		|-> !o_xfer_ack_n_oe && !o_port_data_oe) else $error("ack held");
	a_read_drive: assert property ($rose(o_port_data_oe)
		|-> $past(i_rd_wr_n, 2) && o_xfer_ack_n_oe) else $error("data drive");
	a_write_quiet: assert property ((!i_rd_wr_n)[*8] |-> !o_port_data_oe)
		else $error("data driven on write");
	a_ode_off: assert property ((!i_out_drive_en)[*6] |-> o_serial_out_lines_oe == 8'h00)
		else $error("drive enable");
	a_reset_idle: assert property ($past(i_srst)
		|-> o_serial_out_lines_oe == 8'h00 && o_ctrl_serial_out) else $error("reset state");
	a_bit_hold: assert property ($changed(o_serial_out_lines)
		|=> $stable(o_serial_out_lines)[*8]) else $error("bit cell");
	a_ctrl_hold: assert property ($changed(o_ctrl_serial_out)
		|=> $stable(o_ctrl_serial_out)[*8]) else $error("ctrl cell");
endmodule

// >>> verification/tsw_cpu_model.sv
// Purpose: Processor on the parallel port
// Assumes: Signals change at the falling clock edge
// Notes:   Released data lines show the inverted last value
`timescale 1ns/1ps
module tsw_cpu_model (
	// Clock
	input  wire       i_sys_clk,
	// Bus lines
	input  wire       i_ack_n,
	input  wire [7:0] i_data,
	output reg        o_cs_n,
	output reg        o_strobe,
	output reg        o_rd_wr_n,
	output reg  [5:0] o_addr,
	output reg  [7:0] o_data
);
	initial begin
		o_cs_n = 1'b1;
		o_strobe = 1'b0;
		o_rd_wr_n = 1'b1;
		o_addr = 6'h00;
		o_data = 8'h00;
	end
	// One access; sel low keeps chip select off
	task automatic xfer(input logic sel, input logic rd, input logic [5:0] a,
		input logic [7:0] wd, output logic got, output logic [7:0] rdat);
		got = 1'b0;
		rdat = 8'h00;
		@(negedge i_sys_clk);
		o_cs_n <= ~sel;
		o_strobe <= 1'b1;
		o_rd_wr_n <= rd;
		o_addr <= a;
		o_data <= rd ? ~o_data : wd;
		for (int i = 0; i < 30 && !got; i++) begin
			@(posedge i_sys_clk);
			got = !i_ack_n;
			rdat = i_data;
		end
		@(negedge i_sys_clk);
		o_strobe <= 1'b0;
		o_cs_n <= 1'b1;
		for (int i = 0; i < 20 && !i_ack_n; i++) @(posedge i_sys_clk);
	endtask
endmodule

// >>> verification/tsw_switch_tb_top.sv
// Purpose: Self-checking bench for tsw_switch
// Assumes: Processor model on the port
// Notes:   Link clock runs free
`timescale 1ns/1ps
module tsw_switch_tb_top;
	logic       i_sys_clk = 1'b0;
	logic       i_srst = 1'b1;
	logic       sclk = 1'b0;
	logic       fs_n = 1'b1;
	logic       out_drive_en = 1'b1;
	logic [7:0] sin = 8'h00;
	logic [8:0] fc = 9'h000;
	logic [7:0] t;
	logic [7:0] ob [256];
	logic [7:0] oeb [256];
	logic       cb [256];
	wire        cs_n, ds, rw, ack_oe, pd_oe, ack_raw, cso;
	wire  [5:0] addr;
	wire  [7:0] wd, pd, so, so_oe;
	wire        ack_n = ack_oe ? ack_raw : 1'b1;
	wire  [7:0] bus = pd_oe ? pd : wd;
	int         n_mismatch = 0;
	int         comparisons = 0;
	int         cyc = 0;
	tsw_switch dut (.i_sys_clk, .i_srst, .i_serial_clk_4x(sclk), .i_frame_sync_n(fs_n),
		.i_serial_in_lines(sin), .o_serial_out_lines(so), .o_serial_out_lines_oe(so_oe),
		.i_out_drive_en(out_drive_en), .o_ctrl_serial_out(cso), .i_cs_n(cs_n), .i_data_strobe(ds),
		.i_rd_wr_n(rw), .i_port_addr(addr), .i_port_data(bus), .o_port_data(pd),
		.o_port_data_oe(pd_oe), .o_xfer_ack_n(ack_raw), .o_xfer_ack_n_oe(ack_oe));
	tsw_cpu_model u_cpu (.i_sys_clk, .i_ack_n(ack_n), .i_data(bus), .o_cs_n(cs_n),
		.o_strobe(ds), .o_rd_wr_n(rw), .o_addr(addr), .o_data(wd));
	initial forever #50 i_sys_clk = ~i_sys_clk;
	initial forever #400 sclk = ~sclk;
	always @(negedge sclk) fc <= fc + 9'h001;
	// Frame pulse, input bits, output capture
	always @(posedge sclk) begin
		fs_n <= (fc != 9'h1fe);
		for (int g = 0; g < 8; g++) begin
			t = {g[2:0], fc[8:4]};
			if (!fc[0]) sin[g] <= t[3'h7 - fc[3:1]];
		end
		if (fc[0]) begin
			ob[fc[8:1]] <= so;
			oeb[fc[8:1]] <= so_oe;
			cb[fc[8:1]] <= cso;
		end
	end
	always @(posedge i_sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Drive enable in bit 8, byte MSB first below
	function automatic logic [8:0] obyte(int s, int c);
		logic [8:0] r;
		r = 9'h100;
		for (int b = 0; b < 8; b++) r = {r[8] & oeb[c*8+b][s], r[6:0], ob[c*8+b][s]};
		return r;
	endfunction
	task automatic acc(input logic rd, input logic [5:0] a, input logic [7:0] d);
		logic g;
		logic [7:0] r;
		u_cpu.xfer(1'b1, rd, a, d, g, r);
		chk("ack", 9'h001, {8'h00, g});
		if (rd) chk("read data", {1'b0, d}, {1'b0, r});
	endtask
	task automatic t_ctrl();
		logic g;
		logic [7:0] r;
		acc(1'b0, 6'h00, 8'h1b);
		acc(1'b1, 6'h1f, 8'h1b);
		u_cpu.xfer(1'b0, 1'b0, 6'h00, 8'hff, g, r);
		chk("refused ack", 9'h000, {8'h00, g});
		acc(1'b1, 6'h05, 8'h1b);
	endtask
	task automatic t_switch();
		acc(1'b0, 6'h00, 8'h11);
		acc(1'b0, 6'h23, 8'h47);
		acc(1'b1, 6'h23, 8'h47);
		acc(1'b0, 6'h00, 8'h19);
		acc(1'b0, 6'h23, 8'h03);
		acc(1'b0, 6'h00, 8'h10);
		acc(1'b0, 6'h25, 8'ha5);
		acc(1'b0, 6'h00, 8'h18);
		acc(1'b0, 6'h25, 8'h05);
		repeat (3) @(posedge sclk iff fc == 9'h000);
		chk("stream1 ch3", 9'h147, obyte(1, 3));
		chk("stream0 ch5", 9'h1a5, obyte(0, 5));
		chk("stream0 ch6 oe", 9'h000, obyte(0, 6) & 9'h100);
		chk("ctrl bit 35", 9'h001, {8'h00, cb[35]});
		chk("ctrl bit 36", 9'h000, {8'h00, cb[36]});
		acc(1'b0, 6'h00, 8'h02);
		acc(1'b1, 6'h27, 8'h47);
	endtask
	task automatic t_ode();
		acc(1'b0, 6'h00, 8'h92);
		acc(1'b1, 6'h27, 8'h47);
		acc(1'b0, 6'h27, 8'h5a);
		acc(1'b0, 6'h00, 8'h12);
		acc(1'b1, 6'h27, 8'h5a);
		acc(1'b0, 6'h00, 8'h40);
		repeat (300) @(negedge i_sys_clk);
		chk("all message oe", 9'h0ff, {1'b0, so_oe});
		out_drive_en = 1'b0;
		repeat (8) @(negedge i_sys_clk);
		chk("drive enable off", 9'h000, {1'b0, so_oe});
		out_drive_en = 1'b1;
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (5) @(negedge i_sys_clk);
		i_srst = 1'b0;
		t_ctrl();
		t_switch();
		t_ode();
		tally_and_finish();
	end
endmodule
bind tsw_switch tsw_switch_assertions u_chk (.i_sys_clk, .i_srst, .i_out_drive_en, .i_cs_n,
	.i_data_strobe, .i_rd_wr_n, .o_serial_out_lines, .o_serial_out_lines_oe,
	.o_ctrl_serial_out, .o_port_data_oe, .o_xfer_ack_n, .o_xfer_ack_n_oe);
